//--- hdl/bder_err_report.sv
// Uncorrectable data and address error reporting of a PCIe-to-PCI bridge.
// Assumes every event input is a one-cycle pulse synchronous to clk_i,
// and that the pad logic resolves the parity error pin from its enable.
`timescale 1ns/1ps
`default_nettype none

`include "bder_map.svh"

module bder_err_report
	import bder_pkg::*;
#(
	parameter int NCLS = `BDER_NCLS,
	parameter int NST  = `BDER_NST
)
(
	input  wire logic            clk_i,
	input  wire logic            sys_rst_i,
	input  wire logic            ce_i,
	input  wire logic            pcie_imm_data_err_i,
	input  wire logic            pcie_npw_perr_seen_i,
	input  wire logic            pcie_pw_perr_seen_i,
	input  wire logic            pcie_serr_seen_i,
	input  wire logic            pci_npw_data_err_i,
	input  wire logic            pci_pw_data_err_i,
	input  wire logic            pci_drc_data_err_i,
	input  wire logic            pci_addr_err_i,
	input  wire logic            secondary_parity_response_en_i,
	input  wire logic            system_error_report_en_i,
	input  wire logic            err_msg_en_i,
	input  wire logic [NCLS-1:0] severity_fatal_i,
	input  wire logic [NST-1:0]  status_clr_i,
	output var  logic            detected_parity_error_o,
	output var  logic            fatal_error_detected_o,
	output var  logic            nonfatal_error_detected_o,
	output var  logic            system_error_flag_o,
	output var  logic            sec_detected_parity_error_o,
	output var  logic            master_data_parity_seen_o,
	output var  logic            sec_received_system_error_o,
	output var  logic            signaled_target_abort_o,
	output var  logic            sec_uncorr_data_err_o,
	output var  logic            sec_parity_asserted_err_o,
	output var  logic            sec_syserr_asserted_err_o,
	output var  logic            sec_uncorr_addr_err_o,
	output var  logic            parity_error_pin_n_o,
	output var  logic            parity_error_pin_oe_o,
	output var  logic            err_fatal_msg_o,
	output var  logic            err_nonfatal_msg_o
);

	logic [NCLS-1:0] cls_ev;
	logic            fatal_ev;
	logic            nonfatal_ev;
	logic            fatal_msg;
	logic            nonfatal_msg;
	logic            syserr_set;
	logic            pin_req;
	logic            mdp_set;
	logic            sec_dpe_set;
	logic            ude_set;
	logic            pae_set;

	bder_pin_e       pin_ff;
	bder_pin_e       nxt_pin;
	logic            pin_n_ff;
	logic            nxt_pin_n;
	logic            pin_oe_ff;
	logic            nxt_pin_oe;
	logic            fmsg_ff;
	logic            nxt_fmsg;
	logic            nfmsg_ff;
	logic            nxt_nfmsg;

	// Classes whose error counts toward the device-status detected flags.
	always_comb
	begin
		cls_ev                      = '0;
		cls_ev[`BDER_CL_IMM]        = pcie_imm_data_err_i;
		cls_ev[`BDER_CL_NPW_PERR]   = pcie_npw_perr_seen_i;
		cls_ev[`BDER_CL_PCI_NPW]    = pci_npw_data_err_i;
		cls_ev[`BDER_CL_PCI_PW]     = pci_pw_data_err_i;
		cls_ev[`BDER_CL_DRC]        = pci_drc_data_err_i;
	end

	// Severity picks the flag and the message kind per class.
	assign fatal_ev     = |(cls_ev & severity_fatal_i);
	assign nonfatal_ev  = |(cls_ev & ~severity_fatal_i);
	assign fatal_msg    = fatal_ev & err_msg_en_i;
	assign nonfatal_msg = nonfatal_ev & err_msg_en_i;
	assign syserr_set   = (fatal_msg | nonfatal_msg) & system_error_report_en_i;

	assign pin_req     = (pcie_imm_data_err_i | pci_pw_data_err_i) & secondary_parity_response_en_i;
	assign mdp_set     = (pcie_imm_data_err_i | pcie_pw_perr_seen_i | pci_pw_data_err_i)
	                     & secondary_parity_response_en_i;
	assign sec_dpe_set = pci_npw_data_err_i | pci_pw_data_err_i | pci_addr_err_i;
	assign ude_set     = pcie_imm_data_err_i | pci_npw_data_err_i | pci_pw_data_err_i;
	assign pae_set     = pcie_npw_perr_seen_i | pcie_pw_perr_seen_i | pci_drc_data_err_i;

	bder_sticky u_dpe (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (pcie_imm_data_err_i),
		.clr_i     (status_clr_i[`BDER_ST_DPE]),
		.flag_o    (detected_parity_error_o)
	);

	bder_sticky u_fatal (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (fatal_ev),
		.clr_i     (status_clr_i[`BDER_ST_FATAL]),
		.flag_o    (fatal_error_detected_o)
	);

	bder_sticky u_nfatal (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (nonfatal_ev),
		.clr_i     (status_clr_i[`BDER_ST_NFATAL]),
		.flag_o    (nonfatal_error_detected_o)
	);

	bder_sticky u_syserr (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (syserr_set),
		.clr_i     (status_clr_i[`BDER_ST_SYSERR]),
		.flag_o    (system_error_flag_o)
	);

	bder_sticky u_sec_dpe (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (sec_dpe_set),
		.clr_i     (status_clr_i[`BDER_ST_SEC_DPE]),
		.flag_o    (sec_detected_parity_error_o)
	);

	bder_sticky u_mdp (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (mdp_set),
		.clr_i     (status_clr_i[`BDER_ST_MDP]),
		.flag_o    (master_data_parity_seen_o)
	);

	bder_sticky u_sec_rse (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (pcie_serr_seen_i),
		.clr_i     (status_clr_i[`BDER_ST_SEC_RSE]),
		.flag_o    (sec_received_system_error_o)
	);

	bder_sticky u_sta (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (pci_addr_err_i),
		.clr_i     (status_clr_i[`BDER_ST_STA]),
		.flag_o    (signaled_target_abort_o)
	);

	bder_sticky u_ude (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (ude_set),
		.clr_i     (status_clr_i[`BDER_ST_UDE]),
		.flag_o    (sec_uncorr_data_err_o)
	);

	bder_sticky u_pae (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (pae_set),
		.clr_i     (status_clr_i[`BDER_ST_PAE]),
		.flag_o    (sec_parity_asserted_err_o)
	);

	bder_sticky u_sae (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (pcie_serr_seen_i),
		.clr_i     (status_clr_i[`BDER_ST_SAE]),
		.flag_o    (sec_syserr_asserted_err_o)
	);

	bder_sticky u_uae (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.set_i     (pci_addr_err_i),
		.clr_i     (status_clr_i[`BDER_ST_UAE]),
		.flag_o    (sec_uncorr_addr_err_o)
	);

	// The pin is sustained tri-state: one cycle low, one cycle driven high,
	// then released, so the bus never floats from low straight to idle.
	// A new request during either phase restarts the low phase.
	always_comb
	begin
		nxt_pin    = pin_ff;
		nxt_pin_n  = pin_n_ff;
		nxt_pin_oe = pin_oe_ff;
		nxt_fmsg   = fmsg_ff;
		nxt_nfmsg  = nfmsg_ff;
		if (ce_i)
		begin
			nxt_fmsg  = fatal_msg;
			nxt_nfmsg = nonfatal_msg;
			if (pin_req)
				nxt_pin = PIN_LOW;
			else
			begin
				case (pin_ff)
					PIN_IDLE: nxt_pin = PIN_IDLE;
					PIN_LOW:  nxt_pin = PIN_HIGH;
					PIN_HIGH: nxt_pin = PIN_IDLE;
					default:  nxt_pin = PIN_IDLE;
				endcase
			end
			nxt_pin_n  = (nxt_pin != PIN_LOW);
			nxt_pin_oe = (nxt_pin != PIN_IDLE);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pin_ff    <= PIN_IDLE;
			pin_n_ff  <= `BDER_PIN_N_RST;
			pin_oe_ff <= `BDER_OE_RST;
			fmsg_ff   <= `BDER_MSG_RST;
			nfmsg_ff  <= `BDER_MSG_RST;
		end
		else
		begin
			pin_ff    <= nxt_pin;
			pin_n_ff  <= nxt_pin_n;
			pin_oe_ff <= nxt_pin_oe;
			fmsg_ff   <= nxt_fmsg;
			nfmsg_ff  <= nxt_nfmsg;
		end
	end

	assign parity_error_pin_n_o  = pin_n_ff;
	assign parity_error_pin_oe_o = pin_oe_ff;
	assign err_fatal_msg_o       = fmsg_ff;
	assign err_nonfatal_msg_o    = nfmsg_ff;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence pin_low_s;
		!parity_error_pin_n_o && parity_error_pin_oe_o;
	endsequence

	sequence pin_high_s;
		parity_error_pin_n_o && parity_error_pin_oe_o;
	endsequence

	prim_parity_a: assert property (ce_i && pcie_imm_data_err_i |=> detected_parity_error_o
		&& (fatal_error_detected_o || nonfatal_error_detected_o))
		else $error("immediate data error did not set primary flags");
	imm_pin_a: assert property (ce_i && pcie_imm_data_err_i && secondary_parity_response_en_i
		|=> pin_low_s)
		else $error("parity pin not driven low");
	imm_nopin_a: assert property (ce_i && !pin_req && !parity_error_pin_oe_o
		|=> !parity_error_pin_oe_o)
		else $error("parity pin driven without enable");
	pin_phase_a: assert property ((ce_i && !pin_req) ##0 pin_low_s |=> pin_high_s)
		else $error("parity pin low phase not followed by driven high");
	imm_data_a: assert property (ce_i && pcie_imm_data_err_i |=> sec_uncorr_data_err_o
		&& (master_data_parity_seen_o || !$past(secondary_parity_response_en_i)
		|| $past(master_data_parity_seen_o, 2)))
		else $error("immediate data error secondary flags wrong");
	syserr_flag_a: assert property ($past(ce_i) && (err_fatal_msg_o || err_nonfatal_msg_o)
		&& $past(system_error_report_en_i) |-> system_error_flag_o)
		else $error("message sent without system error flag");
	npw_perr_a: assert property (ce_i && pcie_npw_perr_seen_i |=> sec_parity_asserted_err_o
		&& (fatal_error_detected_o || nonfatal_error_detected_o))
		else $error("non-posted parity error flags not set");
	pw_perr_a: assert property (ce_i && pcie_pw_perr_seen_i && secondary_parity_response_en_i
		|=> sec_parity_asserted_err_o && master_data_parity_seen_o)
		else $error("posted parity error flags not set");
	serr_seen_a: assert property (ce_i && pcie_serr_seen_i
		|=> sec_received_system_error_o && sec_syserr_asserted_err_o)
		else $error("system error flags not set");
	pci_npw_a: assert property (ce_i && pci_npw_data_err_i |=> sec_detected_parity_error_o
		&& sec_uncorr_data_err_o && (fatal_error_detected_o || nonfatal_error_detected_o))
		else $error("pci non-posted data error flags not set");
	pci_pw_a: assert property (ce_i && pci_pw_data_err_i && secondary_parity_response_en_i
		|=> (sec_detected_parity_error_o && sec_uncorr_data_err_o && master_data_parity_seen_o)
		and pin_low_s)
		else $error("pci posted data error reporting wrong");
	drc_err_a: assert property (ce_i && pci_drc_data_err_i |=> sec_parity_asserted_err_o
		&& (fatal_error_detected_o || nonfatal_error_detected_o))
		else $error("delayed read completion error flags not set");
	addr_err_a: assert property (ce_i && pci_addr_err_i |=> sec_detected_parity_error_o
		&& signaled_target_abort_o && sec_uncorr_addr_err_o)
		else $error("address error flags not set");
	msg_sev_a: assert property (ce_i && err_msg_en_i && |cls_ev
		|=> err_fatal_msg_o == $past(fatal_ev) && err_nonfatal_msg_o == $past(nonfatal_ev))
		else $error("error message kind wrong");
	sev_flag_a: assert property (ce_i && pcie_imm_data_err_i && severity_fatal_i[`BDER_CL_IMM]
		|=> fatal_error_detected_o)
		else $error("fatal severity not honoured");

endmodule : bder_err_report

`default_nettype wire

//--- hdl/bder_map.svh
// Constants for the bridge data/address error reporting block.
// Assumes inclusion by bare name from design files only.
`ifndef BDER_MAP_SVH
`define BDER_MAP_SVH

// Number of sticky status flags and their positions in the clear vector.
`define BDER_NST         12
`define BDER_ST_DPE      0
`define BDER_ST_FATAL    1
`define BDER_ST_NFATAL   2
`define BDER_ST_SYSERR   3
`define BDER_ST_SEC_DPE  4
`define BDER_ST_MDP      5
`define BDER_ST_SEC_RSE  6
`define BDER_ST_STA      7
`define BDER_ST_UDE      8
`define BDER_ST_PAE      9
`define BDER_ST_SAE      10
`define BDER_ST_UAE      11

// Error classes that count as detected errors and may raise a message.
`define BDER_NCLS        5
`define BDER_CL_IMM      0
`define BDER_CL_NPW_PERR 1
`define BDER_CL_PCI_NPW  2
`define BDER_CL_PCI_PW   3
`define BDER_CL_DRC      4

// Reset values.
`define BDER_FLAG_RST    1'b0
`define BDER_PIN_N_RST   1'b1
`define BDER_OE_RST      1'b0
`define BDER_MSG_RST     1'b0

`endif

//--- hdl/bder_pkg.sv
// Types shared by the error reporting block.
// Assumes nothing of its surroundings.
package bder_pkg;

	// Drive phases of the sustained tri-state parity error pin.
	typedef enum logic [1:0] {
		PIN_IDLE,
		PIN_LOW,
		PIN_HIGH
	} bder_pin_e;

endpackage : bder_pkg

//--- hdl/bder_sticky.sv
// One sticky status flag: hardware sets, software clears.
// Assumes set and clear are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

`include "bder_map.svh"

module bder_sticky
	import bder_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output var  logic flag_o
);

	logic flag_ff;
	logic nxt_flag;

	// An event arriving with the clear is kept: set wins.
	always_comb
	begin
		nxt_flag = flag_ff;
		if (ce_i)
		begin
			if (set_i)
				nxt_flag = 1'b1;
			else if (clr_i)
				nxt_flag = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			flag_ff <= `BDER_FLAG_RST;
		else
			flag_ff <= nxt_flag;
	end

	assign flag_o = flag_ff;

endmodule : bder_sticky

`default_nettype wire

//--- verification/bder_pci_agent.sv
// Model of the PCI bus agents and upstream link partner seen by the error block.
// Assumes the bench hands it one request bit per event kind each cycle.
`timescale 1ns/1ps
`default_nettype none

module bder_pci_agent
(
	input  wire logic       clk_i,
	input  wire logic [7:0] req_i,
	input  wire logic       pin_n_i,
	input  wire logic       pin_oe_i,
	output var  logic [7:0] ev_o,
	output wire logic       perr_wire_n_o
);
	// Event order: imm, npw perr, pw perr, serr, pci npw, pci pw, drc, addr.
	// Agent errors are one-cycle pulses launched just after the edge.
	always @(posedge clk_i)
	begin
		ev_o <= #1 req_i;
	end
	// A released pin floats back to its pull-up, never to the last driven value.
	assign perr_wire_n_o = pin_oe_i ? pin_n_i : 1'b1;
endmodule : bder_pci_agent

`default_nettype wire

//--- verification/tb_bder_err_report.sv
// Self-checking bench for the error reporting block with a cycle model.
// Assumes the agent model drives the event pulses and resolves the pin.
`timescale 1ns/1ps
`default_nettype none

module tb_bder_err_report
	import bder_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        ce_i = 1'b0;
	logic        resp_en = 1'b0;
	logic        rep_en = 1'b0;
	logic        msg_en = 1'b0;
	logic [4:0]  sev = 5'h00;
	logic [11:0] clr = 12'h000;
	logic [7:0]  req = 8'h00;
	wire  [7:0]  ev;
	logic [11:0] flg;
	logic        pin_n;
	logic        pin_oe;
	logic        fat_msg;
	logic        nf_msg;
	wire         wire_n;
	logic [11:0] flag_ff;
	logic        fat_ff;
	logic        nf_ff;
	int          pin_ff;
	int          bad_count = 0;
	int          comparisons = 0;
	logic [31:0] seed = 32'h39;

	always #25 clk_i = ~clk_i;

	bder_pci_agent agent (.clk_i(clk_i), .req_i(req), .pin_n_i(pin_n), .pin_oe_i(pin_oe),
		.ev_o(ev), .perr_wire_n_o(wire_n));

	bder_err_report dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.pcie_imm_data_err_i(ev[0]), .pcie_npw_perr_seen_i(ev[1]), .pcie_pw_perr_seen_i(ev[2]),
		.pcie_serr_seen_i(ev[3]), .pci_npw_data_err_i(ev[4]), .pci_pw_data_err_i(ev[5]),
		.pci_drc_data_err_i(ev[6]), .pci_addr_err_i(ev[7]),
		.secondary_parity_response_en_i(resp_en), .system_error_report_en_i(rep_en),
		.err_msg_en_i(msg_en), .severity_fatal_i(sev), .status_clr_i(clr),
		.detected_parity_error_o(flg[0]), .fatal_error_detected_o(flg[1]),
		.nonfatal_error_detected_o(flg[2]), .system_error_flag_o(flg[3]),
		.sec_detected_parity_error_o(flg[4]), .master_data_parity_seen_o(flg[5]),
		.sec_received_system_error_o(flg[6]), .signaled_target_abort_o(flg[7]),
		.sec_uncorr_data_err_o(flg[8]), .sec_parity_asserted_err_o(flg[9]),
		.sec_syserr_asserted_err_o(flg[10]), .sec_uncorr_addr_err_o(flg[11]),
		.parity_error_pin_n_o(pin_n), .parity_error_pin_oe_o(pin_oe),
		.err_fatal_msg_o(fat_msg), .err_nonfatal_msg_o(nf_msg));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Reference model: per-cycle set vector, set wins over clear, frozen when ce is low.
	always @(posedge clk_i or posedge sys_rst_i)
	begin : model
		logic [4:0]  cls;
		logic [11:0] s;
		logic        fat;
		logic        nf;
		if (sys_rst_i)
		begin
			flag_ff = 12'h000;
			fat_ff = 1'b0;
			nf_ff = 1'b0;
			pin_ff = 0;
		end
		else if (ce_i)
		begin
			cls = {ev[6], ev[5], ev[4], ev[1], ev[0]};
			fat = (|(cls & sev)) & msg_en;
			nf = (|(cls & ~sev)) & msg_en;
			s[0] = ev[0];
			s[1] = |(cls & sev);
			s[2] = |(cls & ~sev);
			s[3] = (fat | nf) & rep_en;
			s[4] = ev[4] | ev[5] | ev[7];
			s[5] = resp_en & (ev[0] | ev[2] | ev[5]);
			s[6] = ev[3];
			s[7] = ev[7];
			s[8] = ev[0] | ev[4] | ev[5];
			s[9] = ev[1] | ev[2] | ev[6];
			s[10] = ev[3];
			s[11] = ev[7];
			flag_ff = s | (flag_ff & ~clr);
			fat_ff = fat;
			nf_ff = nf;
			if (resp_en & (ev[0] | ev[5]))
				pin_ff = 1;
			else
				pin_ff = (pin_ff == 1) ? 2 : 0;
		end
	end

	task automatic check(input logic [11:0] act, input logic [11:0] exp, input string what);
		comparisons++;
		if (act !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, act, exp);
		end
	endtask : check

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	initial
	begin
		#200000;
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end

	initial
	begin : main
		logic [31:0] r;
		logic [31:0] q;
		repeat (20) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		for (int i = 0; i < 2500; i++)
		begin
			@(posedge clk_i);
			#1;
			check(flg, flag_ff, "status flags");
			check({10'h000, pin_oe, pin_n}, {10'h000, pin_ff != 0, pin_ff != 1}, "pin");
			check({11'h000, wire_n}, {11'h000, pin_ff != 1}, "pin wire");
			check({10'h000, fat_msg, nf_msg}, {10'h000, fat_ff, nf_ff}, "messages");
			r = xs();
			q = xs();
			req = r[7:0] & r[15:8];
			clr = r[27:16] & q[11:0] & q[23:12];
			ce_i = |q[31:29];
			if (r[31:29] == 3'h0)
			begin
				r = xs();
				{resp_en, rep_en, msg_en, sev} = r[7:0];
			end
			if (i == 1200)
				sys_rst_i = 1'b1;
			if (i == 1220)
				sys_rst_i = 1'b0;
		end
		final_report();
	end
endmodule : tb_bder_err_report

`default_nettype wire
